// ==== verilog/card_host_irq_flags.sv ====
// Interrupt flags, mask and revision register of a storage card host interface.
// Assumes event pulses from the protocol engine on clk_sys and an Avalon-MM master.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
module card_host_irq_flags
  import card_irq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Protocol events
  input  wire logic        card_change_evt,
  input  wire logic        timeout_evt,
  input  wire logic        crc_error_evt,
  input  wire logic        card_irq_evt,
  input  wire logic        data_access_need,
  input  wire logic        protocol_ok_evt,
  // Interrupt
  output logic             irq
);
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_type;

  bus_state_type   bus_state_r;
  bus_state_type   bus_state_nxt;
  logic [31:0]     rdata_r;
  logic [31:0]     rdata_nxt;
  logic [5:0]      set_vec;
  logic [5:0]      clr_vec;
  logic [5:0]      en_vec;
  logic [5:0]      dis_vec;
  logic [5:0]      flags;
  logic [5:0]      mask;
  logic            wr_take;
  logic            low_lane;

  // One wait cycle per access: request seen in IDLE, answered in ACK
  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_state_nxt = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_state_nxt = BUS_IDLE;
      end
      default: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  assign avs_waitrequest = (avs_read || avs_write) && (bus_state_r != BUS_ACK);
  assign wr_take         = avs_write && (bus_state_r == BUS_ACK);
  assign low_lane        = avs_byteenable[0];

  // Write strobes decoded on the accepting edge only
  always_comb begin
    clr_vec = 6'h00;
    en_vec  = 6'h00;
    dis_vec = 6'h00;
    if (wr_take && low_lane && avs_address == OFS_CLEAR) begin
      clr_vec = avs_writedata[5:0] & CLEARABLE_MASK;
    end else if (wr_take && low_lane && avs_address == OFS_EN_SET) begin
      en_vec = avs_writedata[5:0];
    end else if (wr_take && low_lane && avs_address == OFS_DIS) begin
      dis_vec = avs_writedata[5:0];
    end
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (avs_read && bus_state_r == BUS_IDLE) begin
      if (avs_address == OFS_STATUS) begin
        rdata_nxt = {26'h0000000, flags};
      end else if (avs_address == OFS_MASK) begin
        rdata_nxt = {26'h0000000, mask};
      end else if (avs_address == OFS_REVISION) begin
        rdata_nxt = {12'h000, REV_VARIANT, 4'h0, REV_NUMBER};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_state_r <= BUS_IDLE;
      rdata_r     <= 32'h00000000;
    end else begin
      bus_state_r <= bus_state_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  assign set_vec[BIT_CARD_CHG] = card_change_evt;
  assign set_vec[BIT_TIMEOUT]  = timeout_evt;
  assign set_vec[BIT_CRC_ERR]  = crc_error_evt;
  assign set_vec[BIT_CARD_INT] = card_irq_evt;
  assign set_vec[BIT_DATA_REQ] = data_access_need;
  assign set_vec[BIT_PROT_END] = protocol_ok_evt;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      // Set wins over clear inside the cell
      flag_cell #(
        .STICKY (g != BIT_DATA_REQ)
      ) u_flag (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .set_in   (set_vec[g]),
        .clr_in   (clr_vec[g]),
        .flag_out (flags[g])
      );
      mask_cell u_mask (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .en_in    (en_vec[g]),
        .dis_in   (dis_vec[g]),
        .mask_out (mask[g])
      );
    end
  endgenerate

  assign irq = |(flags & mask);

  // Interrupt output and flag behaviour
  irq_level_a: assert property (@(posedge clk_sys) disable iff (reset)
    irq == |(flags & mask))
    else $error("irq not tied to flags and mask");

  clear_works_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clr_vec[BIT_TIMEOUT] && !timeout_evt)
    |=> !flags[BIT_TIMEOUT])
    else $error("timeout flag not cleared");

  drq_noclear_a: assert property (@(posedge clk_sys) disable iff (reset)
    clr_vec[BIT_DATA_REQ] == 1'b0)
    else $error("data request got a clear");

  sticky_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (flags[BIT_CARD_CHG] && !clr_vec[BIT_CARD_CHG])
    |=> flags[BIT_CARD_CHG])
    else $error("card change flag dropped");

  drq_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    flags[BIT_DATA_REQ] == $past(data_access_need))
    else $error("data request not following need");

  drq_self_a: assert property (@(posedge clk_sys) disable iff (reset)
    !data_access_need
    |=> !flags[BIT_DATA_REQ])
    else $error("data request stayed without need");

  event_wins_a: assert property (@(posedge clk_sys) disable iff (reset)
    (protocol_ok_evt && clr_vec[BIT_PROT_END])
    |=> flags[BIT_PROT_END])
    else $error("event lost on clear");

  // Mask bits
  mask_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_vec[BIT_CRC_ERR]
    |=> mask[BIT_CRC_ERR])
    else $error("mask not set");

  mask_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    dis_vec[BIT_CARD_INT]
    |=> !mask[BIT_CARD_INT])
    else $error("mask not cleared");

  // Per-source flag and mask properties
  genvar c;
  generate
    for (c = 0; c < NUM_SRC; c++) begin : g_chk
      flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        set_vec[c]
        |=> flags[c])
        else $error("flag not set by its event");

      flag_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
        (!flags[c] && !set_vec[c])
        |=> !flags[c])
        else $error("flag rose without an event");

      flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (clr_vec[c] && !set_vec[c])
        |=> !flags[c])
        else $error("flag not cleared by software");

      mask_on_a: assert property (@(posedge clk_sys) disable iff (reset)
        en_vec[c]
        |=> mask[c])
        else $error("mask bit not enabled");

      mask_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        dis_vec[c]
        |=> !mask[c])
        else $error("mask bit not disabled");

      mask_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        (!en_vec[c] && !dis_vec[c])
        |=> mask[c] == $past(mask[c]))
        else $error("mask bit changed without a write");

      if (c != BIT_DATA_REQ) begin : g_sticky
        flag_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
          (flags[c] && !clr_vec[c])
          |=> flags[c])
          else $error("sticky flag dropped without clear");
      end
    end
  endgenerate

  // Register bus answers
  status_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read && !avs_waitrequest && $past(avs_address == OFS_STATUS && avs_read))
    |-> avs_readdata == {26'h0000000, $past(flags)})
    else $error("status read does not match the flags");

  mask_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read && !avs_waitrequest && $past(avs_address == OFS_MASK && avs_read))
    |-> avs_readdata == {26'h0000000, $past(mask)})
    else $error("mask read does not match the mask");

  rev_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read && !avs_waitrequest && $past(avs_address == OFS_REVISION && avs_read))
    |-> avs_readdata == {12'h000, REV_VARIANT, 4'h0, REV_NUMBER})
    else $error("revision read wrong");

  wo_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read && !avs_waitrequest
      && $past(avs_read && (avs_address == OFS_CLEAR || avs_address == OFS_EN_SET
      || avs_address == OFS_DIS)))
    |-> avs_readdata == 32'h00000000)
    else $error("write-only register read not zero");

  ro_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_write && (avs_address == OFS_STATUS || avs_address == OFS_MASK
      || avs_address == OFS_REVISION))
    |-> (clr_vec == 6'h00 && en_vec == 6'h00 && dis_vec == 6'h00))
    else $error("read-only register took a write");

  strobe_ack_a: assert property (@(posedge clk_sys) disable iff (reset)
    ((|clr_vec) || (|en_vec) || (|dis_vec))
    |-> (avs_write && !avs_waitrequest && low_lane))
    else $error("register changed outside an accepted write");

  lane_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_write && !low_lane)
    |-> (clr_vec == 6'h00 && en_vec == 6'h00 && dis_vec == 6'h00))
    else $error("write acted with low byte lane off");

  rdata_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !(avs_read && bus_state_r == BUS_IDLE)
    |=> $stable(avs_readdata))
    else $error("read data moved without a read");

  wait_one_a: assert property (@(posedge clk_sys) disable iff (reset)
    ($rose(avs_read) && bus_state_r == BUS_IDLE)
    |=> !avs_waitrequest)
    else $error("read not answered in one wait cycle");

  wait_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
    avs_waitrequest
    |=> !avs_waitrequest)
    else $error("more than one wait cycle");

  idle_nowait_a: assert property (@(posedge clk_sys) disable iff (reset)
    !(avs_read || avs_write)
    |-> !avs_waitrequest)
    else $error("waitrequest without a request");

  // Main scenarios
  cov_irq_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(irq));
  cov_clash_c: cover property (@(posedge clk_sys) disable iff (reset)
    card_change_evt && clr_vec[BIT_CARD_CHG]);
  cov_drq_c: cover property (@(posedge clk_sys) disable iff (reset) $fell(flags[BIT_DATA_REQ]));
  cov_lane_c: cover property (@(posedge clk_sys) disable iff (reset)
    avs_write && !avs_waitrequest && !low_lane);
  cov_mask_rd_c: cover property (@(posedge clk_sys) disable iff (reset)
    avs_read && !avs_waitrequest && mask != 6'h00);
endmodule : card_host_irq_flags

// ==== verilog/card_irq_pkg.sv ====
// Package for the card host interrupt flag block: offsets, bit positions, reset values.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package card_irq_pkg;
  localparam int          NUM_SRC        = 6;
  localparam int          ADDR_W         = 6;
  localparam logic [5:0]  OFS_STATUS     = 6'h10;
  localparam logic [5:0]  OFS_CLEAR      = 6'h14;
  localparam logic [5:0]  OFS_EN_SET     = 6'h18;
  localparam logic [5:0]  OFS_DIS        = 6'h1c;
  localparam logic [5:0]  OFS_MASK       = 6'h20;
  localparam logic [5:0]  OFS_REVISION   = 6'h24;
  localparam int          BIT_PROT_END   = 0;
  localparam int          BIT_DATA_REQ   = 1;
  localparam int          BIT_CARD_INT   = 2;
  localparam int          BIT_CRC_ERR    = 3;
  localparam int          BIT_TIMEOUT    = 4;
  localparam int          BIT_CARD_CHG   = 5;
  // Flags that software may clear; the data request bit is self clearing
  localparam logic [5:0]  CLEARABLE_MASK = 6'h3d;
  localparam logic [5:0]  STATUS_RESET   = 6'h00;
  localparam logic [5:0]  MASK_RESET     = 6'h00;
  // Arbitrary neutral revision values
  localparam logic [11:0] REV_NUMBER     = 12'h001;
  localparam logic [3:0]  REV_VARIANT    = 4'h0;
  localparam int          REV_VAR_POS    = 16;
endpackage : card_irq_pkg

// ==== verilog/flag_cell.sv ====
// One sticky or level-following status flag.
// Assumes set and clear are single-cycle requests in the clk_sys domain.
`timescale 1ns/10ps
module flag_cell
  import card_irq_pkg::*;
#(
  parameter bit STICKY = 1'b1
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Control
  input  wire logic set_in,
  input  wire logic clr_in,
  // State
  output logic      flag_out
);
  logic flag_r;
  logic flag_nxt;

  always_comb begin
    if (!STICKY) begin
      flag_nxt = set_in;
    end else if (set_in) begin
      flag_nxt = 1'b1;
    end else if (clr_in) begin
      flag_nxt = 1'b0;
    end else begin
      flag_nxt = flag_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;

  set_wins_a: assert property (@(posedge clk_sys) disable iff (reset)
    set_in |=> flag_r) else $error("flag lost on set");
endmodule : flag_cell

// ==== verilog/mask_cell.sv ====
// One interrupt mask bit with separate set and clear strobes.
// Assumes strobes come from bus writes in the clk_sys domain.
`timescale 1ns/10ps
module mask_cell
  import card_irq_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Control
  input  wire logic en_in,
  input  wire logic dis_in,
  // State
  output logic      mask_out
);
  logic mask_r;
  logic mask_nxt;

  // Both strobes cannot meet: they come from different addresses
  always_comb begin
    if (en_in) begin
      mask_nxt = 1'b1;
    end else if (dis_in) begin
      mask_nxt = 1'b0;
    end else begin
      mask_nxt = mask_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mask_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  assign mask_out = mask_r;
endmodule : mask_cell

// ==== testbench/event_src.sv ====
// Stand-in for the protocol engine and FIFO that raise flag events.
// Assumes the bench drives req on clk_sys edges, bit order as the flags.
`timescale 1ns/10ps
module event_src (
  // Request from bench
  input  wire logic [5:0] req,
  // Events to the flag block
  output logic            chg_e,
  output logic            tmo_e,
  output logic            crc_e,
  output logic            cint_e,
  output logic            need_l,
  output logic            ok_e
);
  assign {chg_e, tmo_e, crc_e} = req[5:3];
  assign {cint_e, need_l, ok_e} = req[2:0];
endmodule : event_src

// ==== testbench/card_host_irq_flags_tb.sv ====
// Self-checking bench for the card host interrupt flag block.
// Assumes event_src feeds events; the bench is the Avalon-MM master.
`timescale 1ns/10ps
module card_host_irq_flags_tb;
  import card_irq_pkg::*;
  logic        clk_sys, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        avs_waitrequest, irq, chg_e, tmo_e, crc_e, cint_e, need_l, ok_e;
  logic [5:0]  avs_address = 6'h00, req = 6'h00, msk_m = 6'h00;
  logic [3:0]  lane_en = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_v, d;
  int          errors = 0, n_checks = 0, i;

  event_src ev_u (.req(req), .chg_e(chg_e), .tmo_e(tmo_e), .crc_e(crc_e),
    .cint_e(cint_e), .need_l(need_l), .ok_e(ok_e));
  card_host_irq_flags dut_u (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(lane_en),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .card_change_evt(chg_e), .timeout_evt(tmo_e), .crc_error_evt(crc_e),
    .card_irq_evt(cint_e), .data_access_need(need_l), .protocol_ok_evt(ok_e),
    .irq(irq));

  function automatic logic irq_exp(input logic [5:0] f, input logic [5:0] m);
    return |(f & m);
  endfunction : irq_exp

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // One access; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= dat;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        errors++;
        report_and_stop();
      end
    end while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd_v, e);
  endtask : rdchk

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    i = $urandom(32'h17dcae5a);
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rdchk("status", OFS_STATUS, 32'h0);
    rdchk("mask", OFS_MASK, 32'h0);
    rdchk("revision", OFS_REVISION, {12'h0, REV_VARIANT, 4'h0, REV_NUMBER});
    rdchk("unmapped", 6'h00, 32'h0);
    rdchk("wo_read", OFS_DIS, 32'h0);
    $display("test reset done");
    for (i = 0; i < NUM_SRC; i++) begin
      @(posedge clk_sys);
      req <= 6'h01 << i;
      @(posedge clk_sys);
      if (i != BIT_DATA_REQ)
        req <= 6'h00;
      @(negedge clk_sys);
      chk("irq_masked", irq, 1'b0);
      bus(1'b1, OFS_EN_SET, 32'h1 << i);
      @(negedge clk_sys);
      chk("irq_on", irq, 1'b1);
      rdchk("flag_set", OFS_STATUS, 32'h1 << i);
      rdchk("mask_set", OFS_MASK, 32'h1 << i);
      bus(1'b1, OFS_CLEAR, 32'h3f);
      rdchk("flag_clr", OFS_STATUS, (i == BIT_DATA_REQ) ? 32'h2 : 32'h0);
      @(posedge clk_sys);
      req <= 6'h00;
      rdchk("need_gone", OFS_STATUS, 32'h0);
      bus(1'b1, OFS_DIS, 32'h3f);
      rdchk("mask_clr", OFS_MASK, 32'h0);
    end
    $display("test per source done");
    @(posedge clk_sys);
    req <= 6'h3d;
    bus(1'b1, OFS_CLEAR, 32'h3d);
    req <= 6'h00;
    rdchk("set_wins", OFS_STATUS, 32'h3d);
    bus(1'b1, OFS_STATUS, 32'h0);
    bus(1'b1, OFS_CLEAR, 32'h0);
    rdchk("ro_zero", OFS_STATUS, 32'h3d);
    bus(1'b1, OFS_CLEAR, 32'h3d);
    lane_en <= 4'he;
    bus(1'b1, OFS_EN_SET, 32'h3f);
    lane_en <= 4'hf;
    rdchk("lane_off", OFS_MASK, 32'h0);
    $display("test collision done");
    repeat (8) begin
      d = $urandom;
      bus(1'b1, OFS_EN_SET, d);
      msk_m = msk_m | d[5:0];
      d = $urandom;
      bus(1'b1, OFS_DIS, d);
      msk_m = msk_m & ~d[5:0];
      rdchk("mask_rand", OFS_MASK, {26'h0, msk_m});
      d = $urandom;
      @(posedge clk_sys);
      req <= d[5:0];
      @(posedge clk_sys);
      req <= 6'h00;
      @(negedge clk_sys);
      chk("irq_rand", irq, irq_exp(d[5:0], msk_m));
      bus(1'b1, OFS_CLEAR, 32'h3d);
    end
    $display("test random done");
    report_and_stop();
  end
endmodule : card_host_irq_flags_tb
